/* verilog/wdt_pkg.sv */
/*
  wdt_pkg: register map, field layout, reset values and rate table
  for the windowed watchdog timer.
  Assumes: 32-bit AXI4-Lite data, one register per aligned word.
*/
package wdt_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] WDT_IDX_ARM = 8'h3F;
  localparam logic [7:0] WDT_IDX_CONTROL = 8'h3E;
  localparam logic [7:0] WDT_IDX_STATUS = 8'h3D;
  localparam logic [7:0] WDT_IDX_MASK = 8'h3C;
  localparam logic [7:0] WDT_IDX_COUNT = 8'h3B;
  localparam int WDT_ADDR_W = 10;

  // control register bit positions
  localparam int WDT_CTL_WINDOW = 7;
  localparam int WDT_CTL_DBG_STOP = 6;
  localparam int WDT_CTL_WMASK = 5;
  localparam int WDT_CTL_CLK_SEL = 3;
  localparam int WDT_CTL_RATE_LSB = 0;

  // status and mask bit positions
  localparam int WDT_ST_TIMEOUT = 0;
  localparam int WDT_ST_BAD_VALUE = 1;
  localparam int WDT_ST_WINDOW = 2;
  localparam int WDT_ST_W = 3;

  // reset values
  localparam logic [2:0] WDT_RATE_RST = 3'h0;
  localparam logic [WDT_ST_W-1:0] WDT_MASK_RST = 3'h0;

  // restart sequence values
  localparam logic [7:0] WDT_ARM_FIRST = 8'h55;
  localparam logic [7:0] WDT_ARM_SECOND = 8'hAA;

  // time-out exponents, in watchdog clock cycles (power of two)
  localparam int WDT_EXP_R1 = 14;
  localparam int WDT_EXP_R2 = 16;
  localparam int WDT_EXP_R3 = 18;
  localparam int WDT_EXP_R4 = 20;
  localparam int WDT_EXP_R5 = 22;
  localparam int WDT_EXP_R6 = 23;
  localparam int WDT_EXP_R7 = 24;
  localparam int WDT_CNT_W = WDT_EXP_R7 + 1;

  // AXI responses
  localparam logic [1:0] WDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDT_RESP_SLVERR = 2'h2;

  // software-visible watchdog configuration
  typedef struct packed {
    logic window_mode_bit;
    logic debug_stop_bit;
    logic watchdog_clock_select;
    logic [2:0] timeout_rate_field;
  } wdt_ctrl_t;

  // one AXI request captured by the slave
  typedef struct packed {
    logic [WDT_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wdt_req_t;

endpackage : wdt_pkg

/* verilog/wdt_sync_edge.sv */
/*
  wdt_sync_edge: two-flop synchroniser with rising-edge detect.
  Assumes: i_async is unrelated to i_clk_sys and is slower than
  half the system clock rate.
*/
`timescale 1ns/100ps
module wdt_sync_edge (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // asynchronous level
  input wire logic i_async,
  // synchronised level and one-cycle rise pulse
  output logic o_level,
  output logic o_rise
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first flop feeds only the second; edge seen on later flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;

endmodule : wdt_sync_edge

/* verilog/wdt_top.sv */
/*
  wdt_top: windowed watchdog with AXI4-Lite register access.
  Assumes: the two oscillator clocks arrive as asynchronous inputs
  well below half of i_clk_sys; debug and special-mode levels come
  from logic on i_clk_sys; o_wdt_reset drives the system reset.
*/
// Contract
// RULE_01: window mode: arm writes only in last quarter
// RULE_02: finished sequence restarts timeout; then wait window
// RULE_03: debug-stop bit halts counters in debug
// RULE_04: masked control write keeps window and rate
// RULE_05: nonzero rate enables; timeout issues system reset
// RULE_06: debug, no stop, special: longest normal period
// RULE_07: rate codes map to two-power cycle counts
// RULE_08: watchdog clock picks RC or external oscillator
// RULE_09: arm register always reads zero
// RULE_10: arm writes ignored while watchdog disabled
// RULE_11: wrong arm value while enabled resets immediately
// RULE_12: software writes first then second value in time
// RULE_13: window and rate write once in normal mode
// RULE_14: interrupted restart sequence ends in reset
`timescale 1ns/100ps
module wdt_top
  import wdt_pkg::*;
#(
  parameter int P_EXP_REDUCE = 0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [WDT_ADDR_W-1:0] i_awaddr,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [WDT_ADDR_W-1:0] i_araddr,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // oscillator clocks, sampled as plain inputs
  input wire logic i_internal_rc_clock,
  input wire logic i_external_osc_clock,
  // chip mode levels
  input wire logic i_debug_mode,
  input wire logic i_special_mode,
  // results
  output logic o_wdt_reset,
  output logic o_rti_halt,
  output logic o_irq
);

  // decode a byte address into a register index, or flag unmapped
  function automatic logic idx_hit(input logic [WDT_ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    idx_hit = (a[1:0] == 2'h0) && (a[WDT_ADDR_W-1:2] == idx);
  endfunction : idx_hit

  function automatic logic mapped(input logic [WDT_ADDR_W-1:0] a);
    mapped = idx_hit(a, WDT_IDX_ARM) || idx_hit(a, WDT_IDX_CONTROL) ||
             idx_hit(a, WDT_IDX_STATUS) || idx_hit(a, WDT_IDX_MASK) ||
             idx_hit(a, WDT_IDX_COUNT);
  endfunction : mapped

  // rate code to time-out exponent
  function automatic logic [4:0] rate_exp(input logic [2:0] r);
    case (r)
      3'h1: rate_exp = 5'(WDT_EXP_R1 - P_EXP_REDUCE); // RULE_07
      3'h2: rate_exp = 5'(WDT_EXP_R2 - P_EXP_REDUCE);
      3'h3: rate_exp = 5'(WDT_EXP_R3 - P_EXP_REDUCE);
      3'h4: rate_exp = 5'(WDT_EXP_R4 - P_EXP_REDUCE);
      3'h5: rate_exp = 5'(WDT_EXP_R5 - P_EXP_REDUCE);
      3'h6: rate_exp = 5'(WDT_EXP_R6 - P_EXP_REDUCE);
      default: rate_exp = 5'(WDT_EXP_R7 - P_EXP_REDUCE);
    endcase
  endfunction : rate_exp

  // oscillator synchronisers: index 0 is RC, index 1 external
  logic [1:0] osc_raw;
  logic [1:0] osc_rise;
  assign osc_raw = {i_external_osc_clock, i_internal_rc_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_osc
      wdt_sync_edge u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(osc_raw[gi]),
        .o_level(),
        .o_rise(osc_rise[gi])
      );
    end
  endgenerate

  // bus slave state
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [WDT_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic arready_q, arready_d;
  logic do_wr;
  logic do_rd;
  wdt_req_t wr_req;

  // watchdog state
  wdt_ctrl_t ctrl_q, ctrl_d;
  logic locked_q, locked_d;
  logic seq_q, seq_d;
  logic [WDT_CNT_W-1:0] cnt_q, cnt_d;
  logic [WDT_ST_W-1:0] status_q, status_d;
  logic [WDT_ST_W-1:0] mask_q, mask_d;
  logic rst_pulse_q, rst_pulse_d;
  logic halt_q, halt_d;
  logic irq_q, irq_d;

  // decoded operating point
  logic enabled;
  logic override;
  logic win_eff;
  logic tick;
  logic [WDT_CNT_W-1:0] period;
  logic [WDT_CNT_W-1:0] win_open;

  always_comb begin
    enabled = (ctrl_q.timeout_rate_field != 3'h0); // RULE_05
    override = enabled && i_debug_mode && !ctrl_q.debug_stop_bit &&
               i_special_mode; // RULE_06
    win_eff = ctrl_q.window_mode_bit && !override; // RULE_06
    period = override ? (WDT_CNT_W'(1) << rate_exp(3'h7)) :
             (WDT_CNT_W'(1) << rate_exp(ctrl_q.timeout_rate_field));
    win_open = period - (period >> 2); // RULE_01
    // clock select picks the sampled oscillator edge
    tick = ctrl_q.watchdog_clock_select ? osc_rise[1] :
           osc_rise[0]; // RULE_08
  end

  // bus handshakes: write fires once both halves are held
  always_comb begin
    do_wr = aw_have_q && w_have_q && !bvalid_q;
    do_rd = i_arvalid && arready_q;
    wr_req = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (i_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = i_awaddr;
    end
    if (i_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = i_wdata;
      wstrb_d = i_wstrb;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(wr_req.addr) ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
    end else if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_rd) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(i_araddr) ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
      rdata_d = 32'h0; // arm register and holes read zero; RULE_09
      if (idx_hit(i_araddr, WDT_IDX_CONTROL)) begin
        rdata_d[WDT_CTL_WINDOW] = ctrl_q.window_mode_bit;
        rdata_d[WDT_CTL_DBG_STOP] = ctrl_q.debug_stop_bit;
        rdata_d[WDT_CTL_CLK_SEL] = ctrl_q.watchdog_clock_select;
        rdata_d[WDT_CTL_RATE_LSB +: 3] = ctrl_q.timeout_rate_field;
      end else if (idx_hit(i_araddr, WDT_IDX_STATUS)) begin
        rdata_d[WDT_ST_W-1:0] = status_q;
      end else if (idx_hit(i_araddr, WDT_IDX_MASK)) begin
        rdata_d[WDT_ST_W-1:0] = mask_q;
      end else if (idx_hit(i_araddr, WDT_IDX_COUNT)) begin
        rdata_d[WDT_CNT_W-1:0] = cnt_q;
      end
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    // one write and one read in flight; ready drops while held
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= WDT_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= WDT_RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  // watchdog core: config, counter, restart sequence, events
  logic wr_lane;
  logic wr_arm;
  logic wr_ctl;
  logic in_window;
  logic [7:0] wb;
  logic [WDT_ST_W-1:0] ev;
  logic [WDT_ST_W-1:0] rd_clr;

  always_comb begin
    wr_lane = do_wr && wr_req.strb[0]; // only byte lane 0 is wired
    wb = wr_req.data[7:0];
    wr_arm = wr_lane && idx_hit(wr_req.addr, WDT_IDX_ARM);
    wr_ctl = wr_lane && idx_hit(wr_req.addr, WDT_IDX_CONTROL);
    in_window = !win_eff || (cnt_q >= win_open);
    ctrl_d = ctrl_q;
    locked_d = locked_q;
    seq_d = seq_q;
    cnt_d = cnt_q;
    mask_d = mask_q;
    ev = '0;
    halt_d = i_debug_mode && ctrl_q.debug_stop_bit; // RULE_03
    // counting; halted in debug when asked, idle when disabled
    if (!enabled) begin
      cnt_d = '0;
      seq_d = 1'b0;
    end else if (tick && !halt_d) begin // RULE_03
      if (cnt_q >= period - WDT_CNT_W'(1)) begin
        ev[WDT_ST_TIMEOUT] = 1'b1; // RULE_05
      end else begin
        cnt_d = cnt_q + WDT_CNT_W'(1);
      end
    end
    // arm register writes only matter while enabled
    if (wr_arm && enabled) begin // RULE_10
      if (wb != WDT_ARM_FIRST && wb != WDT_ARM_SECOND) begin
        ev[WDT_ST_BAD_VALUE] = 1'b1; // RULE_11 RULE_14
      end else if (!in_window) begin
        ev[WDT_ST_WINDOW] = 1'b1; // RULE_01 RULE_02
      end else if (wb == WDT_ARM_FIRST) begin
        seq_d = 1'b1; // repeated first values keep it armed
      end else if (seq_q) begin
        seq_d = 1'b0;
        cnt_d = '0; // RULE_02
      end
    end
    // control: debug-stop anytime, rest once in normal mode (any time in special mode) unless masked
    if (wr_ctl) begin
      ctrl_d.debug_stop_bit = wb[WDT_CTL_DBG_STOP];
      if (!wb[WDT_CTL_WMASK] && (!locked_q || i_special_mode)) begin
        ctrl_d.window_mode_bit = wb[WDT_CTL_WINDOW]; // RULE_04
        ctrl_d.watchdog_clock_select = wb[WDT_CTL_CLK_SEL];
        ctrl_d.timeout_rate_field = wb[WDT_CTL_RATE_LSB +: 3];
        locked_d = locked_q || !i_special_mode; // RULE_13
        cnt_d = '0; // new rate starts a fresh period; RULE_05
        seq_d = 1'b0;
      end
    end
    if (wr_lane && idx_hit(wr_req.addr, WDT_IDX_MASK)) begin
      mask_d = wb[WDT_ST_W-1:0];
    end
    // any reset event restarts the period
    if (ev != '0) begin
      cnt_d = '0;
      seq_d = 1'b0;
    end
    rst_pulse_d = (ev != '0);
    // read clears status; a same-cycle event still wins
    rd_clr = (do_rd && idx_hit(i_araddr, WDT_IDX_STATUS)) ? status_q :
             '0;
    status_d = (status_q & ~rd_clr) | ev;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ctrl_q <= '{default: 1'b0, timeout_rate_field: WDT_RATE_RST};
      locked_q <= 1'b0;
      seq_q <= 1'b0;
      cnt_q <= '0;
      status_q <= '0;
      mask_q <= WDT_MASK_RST;
      rst_pulse_q <= 1'b0;
      halt_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      locked_q <= locked_d;
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rst_pulse_q <= rst_pulse_d;
      halt_q <= halt_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flops
  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_wdt_reset = rst_pulse_q;
  assign o_rti_halt = halt_q;
  assign o_irq = irq_q;

endmodule : wdt_top

/* dv/wdt_top_checker.sv */
/*
  wdt_top_checker: port-level checks of the watchdog.
  Assumes: bound into wdt_top; control writes in data[7:0].
*/
`timescale 1ns/100ps
module wdt_top_checker
  import wdt_pkg::*;
#(
  parameter int P_EXP_REDUCE = 0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [WDT_ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [WDT_ADDR_W-1:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  // modes and results
  input wire logic i_debug_mode,
  input wire logic i_special_mode,
  input wire logic o_wdt_reset,
  input wire logic o_rti_halt
);
  logic [9:0] addr_q;
  logic [7:0] data_q;
  logic strb_q, bv_q, en_q, lock_q, wr_ev, arm_ev, ctl_ev, bad;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // a write acts in the first cycle of its response
  assign wr_ev = o_bvalid && !bv_q && o_bresp == WDT_RESP_OKAY && strb_q;
  assign arm_ev = wr_ev && addr_q == {WDT_IDX_ARM, 2'h0};
  assign ctl_ev = wr_ev && addr_q == {WDT_IDX_CONTROL, 2'h0} &&
    !data_q[WDT_CTL_WMASK] && (!lock_q || i_special_mode);
  assign bad = data_q != 8'h55 && data_q != 8'hAA;

  // shadow enable and lock, so checks need no internal probes
  always_ff @(posedge i_clk_sys) begin
    if (i_awvalid && o_awready) addr_q <= i_awaddr;
    if (i_wvalid && o_wready) data_q <= i_wdata[7:0];
    if (i_wvalid && o_wready) strb_q <= i_wstrb[0];
    if (!i_rst_b) begin
      bv_q <= 1'b0;
      en_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      bv_q <= o_bvalid;
      if (ctl_ev) en_q <= data_q[2:0] != 3'h0;
      if (ctl_ev && !i_special_mode) lock_q <= 1'b1;
    end
  end

  sequence s_first;
    arm_ev && en_q && data_q == 8'h55;
  endsequence
  sequence s_bad;
    arm_ev && en_q && bad;
  endsequence
  property p_arm_zero;
    i_arvalid && o_arready && i_araddr == {WDT_IDX_ARM, 2'h0}
      |=> o_rvalid && o_rdata == 32'h0;
  endproperty
  property p_off_ignored;
    arm_ev && !en_q |-> !o_wdt_reset;
  endproperty
  property p_bad_resets;
    s_bad |-> o_wdt_reset;
  endproperty
  property p_broken_seq;
    s_first ##[1:300] s_bad |-> o_wdt_reset;
  endproperty
  property p_pulse;
    o_wdt_reset |=> !o_wdt_reset;
  endproperty
  property p_off_quiet;
    !en_q |-> !o_wdt_reset;
  endproperty
  property p_halt_cause;
    o_rti_halt |-> $past(i_debug_mode);
  endproperty
  property p_halt_drop;
    $fell(i_debug_mode) |=> !o_rti_halt;
  endproperty

  a_arm_zero: assert property (p_arm_zero)
    else $error("arm read not zero");
  a_off_ignored: assert property (p_off_ignored)
    else $error("arm write acted while disabled");
  a_bad_resets: assert property (p_bad_resets)
    else $error("wrong arm value gave no reset");
  a_broken_seq: assert property (p_broken_seq)
    else $error("broken restart gave no reset");
  a_pulse: assert property (p_pulse)
    else $error("reset pulse too long");
  a_off_quiet: assert property (p_off_quiet)
    else $error("reset while disabled");
  a_halt_cause: assert property (p_halt_cause)
    else $error("halt without debug");
  a_halt_drop: assert property (p_halt_drop)
    else $error("halt kept after debug");
endmodule : wdt_top_checker

bind wdt_top wdt_top_checker #(.P_EXP_REDUCE(P_EXP_REDUCE))
  wdt_top_checker_inst (
  .i_clk_sys, .i_rst_b, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
  .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .o_bresp, .i_arvalid,
  .o_arready, .i_araddr, .o_rvalid, .o_rdata, .i_debug_mode,
  .i_special_mode, .o_wdt_reset, .o_rti_halt
);

/* dv/wdt_top_bench.sv */
/*
  wdt_top_bench: register-level tests of the watchdog.
  Assumes: counts shortened by P_EXP_REDUCE; oscillators made here.
*/
`timescale 1ns/100ps
module wdt_top_bench
  import wdt_pkg::*;
;
  localparam int RED = 11;
  localparam logic [9:0] A_ARM = {WDT_IDX_ARM, 2'h0};
  localparam logic [9:0] A_CTL = {WDT_IDX_CONTROL, 2'h0};
  localparam logic [9:0] A_ST = {WDT_IDX_STATUS, 2'h0};
  localparam logic [9:0] A_MSK = {WDT_IDX_MASK, 2'h0};
  localparam logic [9:0] A_CNT = {WDT_IDX_COUNT, 2'h0};
  logic clk, rst_b, awv, wv, bry, arv, rry, rc, xo, dbg, spc;
  logic awr, wrd, bv, arr, rv, wdr, halt, irq;
  logic [9:0] awa, ara;
  logic [1:0] bresp, rresp;
  logic [31:0] wd, rdat, v, c0, rs;
  int n_mismatch, n_compared, n_rst, t;
  int ex[7] = '{14, 16, 18, 20, 22, 23, 24};

  // system clock; oscillators free-running, off the clock edges
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rc = 1'b0;
    #3;
    forever #15 rc = ~rc;
  end
  initial begin
    xo = 1'b0;
    #2;
    forever #25 xo = ~xo;
  end

  // reset pulses, counted as seen before each edge
  always @(posedge clk) if (wdr === 1'b1) n_rst <= n_rst + 1;

  wdt_top #(.P_EXP_REDUCE(RED)) wdt_top_inst (
    .i_clk_sys(clk), .i_rst_b(rst_b),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
    .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'hF),
    .o_bvalid(bv), .i_bready(bry), .o_bresp(bresp),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
    .o_rvalid(rv), .i_rready(rry), .o_rdata(rdat), .o_rresp(rresp),
    .i_internal_rc_clock(rc), .i_external_osc_clock(xo),
    .i_debug_mode(dbg), .i_special_mode(spc),
    .o_wdt_reset(wdr), .o_rti_halt(halt), .o_irq(irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // one write; rs keeps response code and reset level of its answer
  // no local limit: only the bench's hang timer ends a wait for the answer
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    rs = {29'h0, bresp, wdr};
    bry <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [31:0] q);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    q = rdat;
    rry <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask : rdc

  // time to the next reset pulse, p periods of m system cycles
  task automatic expire(input int p, input int m);
    int base, k;
    base = n_rst;
    k = 0;
    while (n_rst == base && k < m * p + 20) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, k >= m * p - 6 && k <= m * p + 12}, 32'h1);
  endtask : expire

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // cuts a hang short at about twice the expected run
  initial begin
    #1000000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    {awv, wv, bry, arv, rry, dbg, rst_b} = '0;
    {awa, ara, wd} = '0;
    spc = 1'b1;
    cyc(12);
    rst_b <= 1'b1;
    cyc(2);
    rdc(A_CTL, 32'h0);
    rdc(A_MSK, 32'h0);
    rdc(A_ARM, 32'h0);
    rd(10'h004, v);
    chk({30'h0, rresp}, {30'h0, WDT_RESP_SLVERR});
    wr(10'h004, 8'h00);
    chk(rs, {29'h0, WDT_RESP_SLVERR, 1'b0});
    // every rate code, then the second oscillator
    for (int r = 1; r < 8; r++) begin
      wr(A_CTL, 8'(r));
      expire(1 << (ex[r - 1] - RED), 3);
    end
    wr(A_CTL, 8'h09);
    expire(1 << (ex[0] - RED), 5);
    wr(A_CTL, 8'h00);
    t = n_rst;
    wr(A_ARM, 8'h3C);
    cyc(60);
    chk(n_rst, t);
    // restarts kept up across several periods
    wr(A_CTL, 8'h03);
    repeat (4) begin
      cyc(250);
      wr(A_ARM, 8'h55);
      rd(A_ST, v);
      wr(A_ARM, 8'h55);
      wr(A_ARM, 8'hAA);
    end
    rd(A_CNT, v);
    chk({31'h0, v < 4}, 32'h1);
    chk(n_rst, t);
    rdc(A_ARM, 32'h0);
    // broken sequence, status and interrupt mask
    wr(A_MSK, 8'h00);
    wr(A_ARM, 8'h55);
    wr(A_ARM, 8'h3C);
    chk(rs, 32'h1);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    wr(A_MSK, 8'h02);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    rdc(A_ST, 32'h2);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    rdc(A_ST, 32'h0);
    wr(A_ARM, 8'h00);
    chk(rs, 32'h1);
    rd(A_ST, v);
    // window mode: early, in window, then early again
    wr(A_CTL, 8'h83);
    wr(A_ARM, 8'h55);
    chk(rs, 32'h1);
    cyc(330);
    wr(A_ARM, 8'h55);
    chk(rs, 32'h0);
    wr(A_ARM, 8'hAA);
    chk(rs, 32'h0);
    wr(A_ARM, 8'h55);
    chk(rs, 32'h1);
    rdc(A_ST, 32'h4);
    // special debug override: window ignored, early first value is fine
    dbg <= 1'b1;
    wr(A_ARM, 8'h55);
    chk(rs, 32'h0);
    dbg <= 1'b0;
    wr(A_CTL, 8'h00);
    // normal mode: write-once, mask, debug stop
    spc <= 1'b0;
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(2);
    wr(A_CTL, 8'h67);
    rdc(A_CTL, 32'h40);
    wr(A_CTL, 8'h42);
    rdc(A_CTL, 32'h42);
    wr(A_CTL, 8'h45);
    rdc(A_CTL, 32'h42);
    dbg <= 1'b1;
    rd(A_CNT, c0);
    cyc(30);
    rdc(A_CNT, c0);
    chk({31'h0, halt}, 32'h1);
    dbg <= 1'b0;
    wr(A_CTL, 8'h27);
    rdc(A_CTL, 32'h02);
    tally_and_finish;
  end
endmodule : wdt_top_bench
